// *** rtl/nco_core.sv ***
// module: numerically controlled oscillator with axi4-lite register slave
// ------------------------------------------------------------
// Overview of operation
// [RULE_01] 20-bit accumulator readable and writable as low, high and upper bytes.
// [RULE_02] each selected input clock edge: accumulator becomes accumulator plus active increment.
// [RULE_03] carry out of that addition is the raw oscillator output.
// [RULE_04] 16-bit increment held in low and high byte registers, both readable and writable.
// [RULE_05] while disabled, increment writes load the internal buffer at once.
// [RULE_06] while enabled, buffer loads on next input edge after low byte write; high first.
// [RULE_07] internal increment buffer cannot be read or written by software.
// [RULE_08] two-bit field selects among four input clock sources.
// [RULE_09] source codes: 11 logic cell, 10 fast oscillator, 01 system clock, 00 pin.
// [RULE_10] fixed duty mode toggles output on each overflow for 50 percent duty.
// [RULE_11] control bit 0 clear selects fixed duty, set selects pulse frequency mode.
// [RULE_12] pulse mode: overflow makes output active for chosen periods, then inactive.
// [RULE_13] pulse mode: output turns active on the input edge right after overflow.
// [RULE_14] three-bit pulse width field applies only in pulse frequency mode.
// [RULE_15] width code n gives two to the power n input clock periods.
// [RULE_16] software keeps pulse width below overflow interval, else behaviour undefined.
// [RULE_17] control bit 4 set inverts output as final stage, clear keeps active high.
// [RULE_18] polarity change with interrupts enabled raises interrupt for resulting transition.
// [RULE_19] read-only control bit 5 shows current output level.
// [RULE_20] each overflow sets flag; irq needs module, peripheral, group and global enables.
// [RULE_21] software clears the overflow flag; hardware never clears it.
// [RULE_22] any reset clears all block registers to zero; pstate_ff resets to NCO_PULSE_IDLE (2'h1) instead.
// [RULE_23] block runs from its selected source independent of system sleep.
// [RULE_24] enabled with fast oscillator selected keeps that oscillator running in sleep.
// [RULE_25] pin driven only while pin output enable set; internal copy always available.
`timescale 1ns/1ps
`default_nettype none
module nco_core (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        internal_fast_oscillator,
    input  wire logic        logic_cell_output,
    input  wire logic        external_clock_pin,
    output logic             nco_pin_out,
    output logic             nco_pin_oe,
    output logic             nco_periph_out,
    output logic             fast_osc_keep_on,
    output logic             irq_out
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic                         en_ff, oe_ff, pol_ff, pfm_ff;
    logic [2:0]                   pws_ff;
    logic [1:0]                   cks_ff;
    logic [nco_pkg::ACC_W-1:0]    acc_ff;
    logic [nco_pkg::INC_W-1:0]    inc_hold_ff;
    logic [nco_pkg::INC_W-1:0]    inc_buf_ff;
    logic                         inc_pend_ff;
    logic                         flag_ff, ie_ff, peripheral_group_enable_ff, gie_ff;
    logic                         raw_ff;
    logic [7:0]                   pcnt_ff;
    nco_pkg::nco_pulse_t          pstate_ff;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic        aw_got_ff, w_got_ff;
    logic [7:0]  waddr_ff;
    logic [7:0]  wbyte_ff;
    logic        wlane_ff;
    logic        wr_fire;
    logic [7:0]  wr_val;
    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= nco_pkg::OFS_IRQ);
    endfunction : addr_ok

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic fire, input logic lane);
        wr_hit = fire && lane && (a == ofs);
    endfunction : wr_hit

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            waddr_ff      <= nco_pkg::RST_BYTE;
            wbyte_ff      <= nco_pkg::RST_BYTE;
            wlane_ff      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= nco_pkg::RESP_OKAY;
        end else begin
            // either channel may arrive first; each ready drops once its item is held
            s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_got_ff && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                waddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(waddr_ff) ? nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_ff     <= 1'b0;
                w_got_ff      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    assign wr_val = wbyte_ff;

    logic w_ctrl, w_clk, w_accl, w_acch, w_accu, w_incl, w_inch, w_irq, w_acc_any;
    assign w_ctrl    = wr_hit(waddr_ff, nco_pkg::OFS_CONTROL, wr_fire, wlane_ff);
    assign w_clk     = wr_hit(waddr_ff, nco_pkg::OFS_INCLK_CTRL, wr_fire, wlane_ff);
    assign w_accl    = wr_hit(waddr_ff, nco_pkg::OFS_ACC_LOW, wr_fire, wlane_ff);
    assign w_acch    = wr_hit(waddr_ff, nco_pkg::OFS_ACC_HIGH, wr_fire, wlane_ff);
    assign w_accu    = wr_hit(waddr_ff, nco_pkg::OFS_ACC_UPPER, wr_fire, wlane_ff);
    assign w_incl    = wr_hit(waddr_ff, nco_pkg::OFS_INC_LOW, wr_fire, wlane_ff);
    assign w_inch    = wr_hit(waddr_ff, nco_pkg::OFS_INC_HIGH, wr_fire, wlane_ff);
    assign w_irq     = wr_hit(waddr_ff, nco_pkg::OFS_IRQ, wr_fire, wlane_ff);
    assign w_acc_any = w_accl || w_acch || w_accu;

    // ------------------------------------------------------------
    // input clock selection
    // ------------------------------------------------------------
    logic [2:0] src_s1_ff, src_s2_ff;
    logic       src_prev_ff;
    logic       src_lvl, tick;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_s1_ff   <= 3'h0;
            src_s2_ff   <= 3'h0;
            src_prev_ff <= 1'b0;
        end else begin
            src_s1_ff   <= {logic_cell_output, internal_fast_oscillator, external_clock_pin};
            src_s2_ff   <= src_s1_ff;
            src_prev_ff <= src_lvl;
        end
    end
    always_comb begin
        case (cks_ff) // [RULE_08] [RULE_09]
            nco_pkg::CKS_EXT_PIN:  src_lvl = src_s2_ff[0];
            nco_pkg::CKS_FAST_OSC: src_lvl = src_s2_ff[1];
            nco_pkg::CKS_LOGIC:    src_lvl = src_s2_ff[2];
            default:               src_lvl = 1'b0;
        endcase
    end
    // the system clock source advances on every core clock; the others on their rising edge
    assign tick = en_ff && ((cks_ff == nco_pkg::CKS_SYS_CLK) || (src_lvl && !src_prev_ff)); // [RULE_08]

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin // [RULE_22]
            en_ff  <= 1'b0;
            oe_ff  <= 1'b0;
            pol_ff <= 1'b0;
            pfm_ff <= 1'b0;
            pws_ff <= 3'h0;
            cks_ff <= 2'h0;
        end else begin
            if (w_ctrl) begin
                en_ff  <= wr_val[nco_pkg::BIT_MODULE_ENABLE];
                oe_ff  <= wr_val[nco_pkg::BIT_PIN_OE];
                pol_ff <= wr_val[nco_pkg::BIT_POLARITY];
                pfm_ff <= wr_val[nco_pkg::BIT_PULSE_MODE]; // [RULE_11]
            end
            if (w_clk) begin
                pws_ff <= wr_val[nco_pkg::PWS_LSB +: 3];
                cks_ff <= wr_val[nco_pkg::CKS_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // increment holding and buffer
    // ------------------------------------------------------------
    logic [nco_pkg::INC_W-1:0] nxt_inc_hold;
    always_comb begin
        nxt_inc_hold = inc_hold_ff;
        if (w_incl) begin
            nxt_inc_hold[7:0] = wr_val;
        end
        if (w_inch) begin
            nxt_inc_hold[15:8] = wr_val;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            inc_hold_ff <= nco_pkg::RST_INC;
            inc_buf_ff  <= nco_pkg::RST_INC;
            inc_pend_ff <= 1'b0;
        end else begin
            inc_hold_ff <= nxt_inc_hold; // [RULE_04]
            if (!en_ff && (w_incl || w_inch)) begin
                inc_buf_ff  <= nxt_inc_hold; // [RULE_05]
                inc_pend_ff <= 1'b0;
            end else if (en_ff && w_incl) begin
                inc_pend_ff <= 1'b1; // [RULE_06]
            end else if (inc_pend_ff && tick) begin
                inc_buf_ff  <= inc_hold_ff; // [RULE_06]
                inc_pend_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and adder
    // ------------------------------------------------------------
    logic [nco_pkg::ACC_W:0] sum;
    logic                    ovf;
    // the add runs off the buffered increment, never the holding bytes
    assign sum = {1'b0, acc_ff} + {5'h00, inc_buf_ff}; // [RULE_02] [RULE_07]
    assign ovf = tick && sum[nco_pkg::ACC_W]; // [RULE_03]
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= nco_pkg::RST_ACC;
        end else if (w_acc_any) begin
            // a software write wins over a coincident add
            if (w_accl) acc_ff[7:0] <= wr_val; // [RULE_01]
            if (w_acch) acc_ff[15:8] <= wr_val;
            if (w_accu) acc_ff[19:16] <= wr_val[3:0];
        end else if (tick) begin
            acc_ff <= sum[nco_pkg::ACC_W-1:0]; // [RULE_02] [RULE_23]
        end
    end

    // ------------------------------------------------------------
    // output shaping
    // ------------------------------------------------------------
    logic [7:0] pw_len;
    assign pw_len = 8'h01 << pws_ff; // [RULE_15]
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_ff    <= 1'b0;
            pcnt_ff   <= 8'h00;
            pstate_ff <= nco_pkg::NCO_PULSE_IDLE;
        end else if (!en_ff) begin
            raw_ff    <= 1'b0;
            pstate_ff <= nco_pkg::NCO_PULSE_IDLE;
        end else if (!pfm_ff) begin
            pstate_ff <= nco_pkg::NCO_PULSE_IDLE;
            if (ovf) raw_ff <= !raw_ff; // [RULE_10]
        end else begin
            case (pstate_ff)
                nco_pkg::NCO_PULSE_IDLE: begin
                    raw_ff <= 1'b0;
                    if (ovf) begin
                        raw_ff    <= 1'b1; // [RULE_13]
                        pcnt_ff   <= pw_len - 8'h01; // [RULE_14]
                        pstate_ff <= nco_pkg::NCO_PULSE_ACTIVE;
                    end
                end
                nco_pkg::NCO_PULSE_ACTIVE: begin
                    // an overflow inside the pulse restarts it; that case is left to software
                    if (ovf) begin
                        pcnt_ff <= pw_len - 8'h01; // [RULE_16]
                    end else if (tick) begin
                        if (pcnt_ff == 8'h00) begin
                            raw_ff    <= 1'b0; // [RULE_12]
                            pstate_ff <= nco_pkg::NCO_PULSE_IDLE;
                        end else begin
                            pcnt_ff <= pcnt_ff - 8'h01;
                        end
                    end
                end
                default: begin
                    raw_ff    <= 1'b0;
                    pstate_ff <= nco_pkg::NCO_PULSE_IDLE;
                end
            endcase
        end
    end

    logic out_lvl;
    assign out_lvl = raw_ff ^ pol_ff; // [RULE_17]
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_periph_out   <= 1'b0;
            nco_pin_out      <= 1'b0;
            nco_pin_oe       <= 1'b0;
            fast_osc_keep_on <= 1'b0;
        end else begin
            nco_periph_out   <= out_lvl; // [RULE_25]
            nco_pin_out      <= oe_ff && out_lvl; // [RULE_25]
            nco_pin_oe       <= oe_ff;
            fast_osc_keep_on <= en_ff && (cks_ff == nco_pkg::CKS_FAST_OSC); // [RULE_24]
        end
    end

    // ------------------------------------------------------------
    // interrupt flag and enables
    // ------------------------------------------------------------
    logic pol_chg;
    assign pol_chg = w_ctrl && (wr_val[nco_pkg::BIT_POLARITY] != pol_ff) && ie_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
            ie_ff   <= 1'b0;
            peripheral_group_enable_ff <= 1'b0;
            gie_ff  <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            if (w_irq) begin
                ie_ff   <= wr_val[nco_pkg::BIT_IRQ_ENABLE];
                peripheral_group_enable_ff <= wr_val[nco_pkg::BIT_GROUP_ENABLE];
                gie_ff  <= wr_val[nco_pkg::BIT_GLOBAL_ENABLE];
            end
            // a set in the clearing cycle wins
            if (ovf || pol_chg) begin
                flag_ff <= 1'b1; // [RULE_20] [RULE_18]
            end else if (w_irq && !wr_val[nco_pkg::BIT_IRQ_FLAG]) begin
                flag_ff <= 1'b0; // [RULE_21]
            end
            irq_out <= flag_ff && en_ff && ie_ff && peripheral_group_enable_ff && gie_ff; // [RULE_20]
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [7:0] rd_val;
    always_comb begin
        case (s_axi_araddr)
            nco_pkg::OFS_CONTROL:    rd_val = {en_ff, oe_ff, out_lvl, pol_ff, 3'h0, pfm_ff}; // [RULE_19]
            nco_pkg::OFS_INCLK_CTRL: rd_val = {pws_ff, 3'h0, cks_ff};
            nco_pkg::OFS_ACC_LOW:    rd_val = acc_ff[7:0];
            nco_pkg::OFS_ACC_HIGH:   rd_val = acc_ff[15:8];
            nco_pkg::OFS_ACC_UPPER:  rd_val = {4'h0, acc_ff[19:16]};
            nco_pkg::OFS_INC_LOW:    rd_val = inc_hold_ff[7:0]; // [RULE_07]
            nco_pkg::OFS_INC_HIGH:   rd_val = inc_hold_ff[15:8];
            nco_pkg::OFS_IRQ:        rd_val = {4'h0, gie_ff, peripheral_group_enable_ff, ie_ff, flag_ff};
            default:                 rd_val = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= nco_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_val};
            s_axi_rresp   <= addr_ok(s_axi_araddr) ? nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_acc_add;
        @(posedge core_clk) disable iff (!rst_n)
        (tick && !w_acc_any) |=> (acc_ff == $past(sum[19:0]));
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("accumulator did not add"); // [RULE_02]

    property p_fdc_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        (ovf && en_ff && !pfm_ff && !w_ctrl) |=> (raw_ff != $past(raw_ff));
    endproperty
    a_fdc_toggle: assert property (p_fdc_toggle) else $error("fixed duty output did not toggle"); // [RULE_10]

    property p_pf_start;
        @(posedge core_clk) disable iff (!rst_n)
        (ovf && pfm_ff && !w_ctrl) |=> raw_ff;
    endproperty
    a_pf_start: assert property (p_pf_start) else $error("pulse not started on overflow"); // [RULE_13]

    property p_pf_one;
        @(posedge core_clk) disable iff (!rst_n)
        (pstate_ff == nco_pkg::NCO_PULSE_ACTIVE && tick && !ovf && pcnt_ff == 8'h00 && !w_ctrl) |=> !raw_ff;
    endproperty
    a_pf_one: assert property (p_pf_one) else $error("pulse did not end"); // [RULE_12]

    property p_flag_set;
        @(posedge core_clk) disable iff (!rst_n)
        ovf |=> flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag not set"); // [RULE_20]

    property p_irq_gate;
        @(posedge core_clk) disable iff (!rst_n)
        irq_out |-> $past(flag_ff && gie_ff && peripheral_group_enable_ff);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without flag and enables"); // [RULE_20]

    property p_inc_now;
        @(posedge core_clk) disable iff (!rst_n)
        (!en_ff && w_inch) |=> (inc_buf_ff[15:8] == $past(wr_val));
    endproperty
    a_inc_now: assert property (p_inc_now) else $error("disabled increment not loaded"); // [RULE_05]

    property p_pin_gate;
        @(posedge core_clk) disable iff (!rst_n)
        !nco_pin_oe |-> !nco_pin_out;
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled"); // [RULE_25]

    property p_bhold;
        @(posedge core_clk) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule : nco_core
`default_nettype wire

// *** rtl/nco_pkg.sv ***
// package: register map, fields, reset values and encodings of the oscillator
package nco_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_INCLK_CTRL = 8'h04;
    localparam logic [7:0] OFS_ACC_LOW    = 8'h08;
    localparam logic [7:0] OFS_ACC_HIGH   = 8'h0c;
    localparam logic [7:0] OFS_ACC_UPPER  = 8'h10;
    localparam logic [7:0] OFS_INC_LOW    = 8'h14;
    localparam logic [7:0] OFS_INC_HIGH   = 8'h18;
    localparam logic [7:0] OFS_IRQ        = 8'h1c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_MODULE_ENABLE = 7;
    localparam int BIT_PIN_OE        = 6;
    localparam int BIT_OUT_STATUS    = 5;
    localparam int BIT_POLARITY      = 4;
    localparam int BIT_PULSE_MODE    = 0;
    localparam int PWS_LSB           = 5;
    localparam int CKS_LSB           = 0;
    localparam int BIT_IRQ_FLAG      = 0;
    localparam int BIT_IRQ_ENABLE    = 1;
    localparam int BIT_GROUP_ENABLE  = 2;
    localparam int BIT_GLOBAL_ENABLE = 3;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int ACC_W = 20;
    localparam int INC_W = 16;
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [19:0] RST_ACC  = 20'h00000;
    localparam logic [15:0] RST_INC  = 16'h0000;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CKS_EXT_PIN  = 2'h0;
    localparam logic [1:0] CKS_SYS_CLK  = 2'h1;
    localparam logic [1:0] CKS_FAST_OSC = 2'h2;
    localparam logic [1:0] CKS_LOGIC    = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    typedef enum logic [1:0] {
        NCO_PULSE_IDLE   = 2'h1,
        NCO_PULSE_ACTIVE = 2'h2
    } nco_pulse_t;
endpackage : nco_pkg

// *** testbench/nco_src_model.sv ***
// clock sources at three fixed, distinct rates
`timescale 1ns/1ps
`default_nettype none
module nco_src_model (
    input  wire logic core_clk,
    output logic      ext_clk,
    output logic      fast_clk,
    output logic      lc_clk
);
    logic [4:0] cnt_ff = 5'h00;
    always_ff @(posedge core_clk) begin
        cnt_ff <= cnt_ff + 5'h01;
    end
    assign ext_clk  = cnt_ff[2];
    assign fast_clk = cnt_ff[3];
    assign lc_clk   = cnt_ff[4];
endmodule : nco_src_model
`default_nettype wire

// *** testbench/testbench.sv ***
// testbench: register, clock source, mode and interrupt checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, one = 1'b1;
    logic [7:0]  awa = 8'h00, ara = 8'h00, wd = 8'h00;
    logic [31:0] rdat;
    logic [1:0]  rrsp, brsp;
    logic        awr, wrd, bv, arr, rv, ext, fst, lc, pin, poe, per, keep, irq, prv;
    logic [33:0] hi;
    int          fails = 0, compares = 0, n, c, p;
    int          dv[4] = '{8, 1, 16, 32};
    always #2.5 core_clk = ~core_clk;
    nco_src_model u_src (.core_clk(core_clk), .ext_clk(ext), .fast_clk(fst), .lc_clk(lc));
    nco_core u_dut (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata({24'h0, wd}),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(one), .s_axi_bresp(brsp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(one), .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .internal_fast_oscillator(fst),
        .logic_cell_output(lc), .external_clock_pin(ext), .nco_pin_out(pin), .nco_pin_oe(poe),
        .nco_periph_out(per), .fast_osc_keep_on(keep), .irq_out(irq));
    task stop_test;
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
        // a wait that ran out is a failure even when the stale value happens to match
        if (n == 99) begin
            fails++;
            stop_test;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        awa <= a;
        wd <= d;
        {awv, wv} <= 2'h3;
        for (n = 0; n < 99; n++) begin
            @(posedge core_clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) break;
        end
        chk("bvalid_bresp", 34'({bv, brsp}), 34'h4);
    endtask : wr
    task rd(input logic [7:0] a, input logic [33:0] e, input string nm);
        ara <= a;
        arv <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge core_clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        chk(nm, {rrsp, rdat}, e);
    endtask : rd
    // pin must track the peripheral copy while its enable is set
    task cnt(input int len, input logic rise, output logic [33:0] r);
        r = 34'h0;
        prv = per;
        repeat (len) begin
            @(posedge core_clk);
            if (rise ? (per && !prv) : per) r++;
            if (pin !== per) r = r + 34'h3e8;
            prv = per;
        end
    endtask : cnt
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h00, 34'h0, "control");
        rd(8'h14, 34'h0, "inc_low");
        rd(8'h20, 34'h200000000, "unmapped");
        wr(8'h10, 8'hff);
        rd(8'h10, 34'h0f, "acc_upper");
        wr(8'h10, 8'h00);
        wr(8'h18, 8'h80);
        rd(8'h18, 34'h80, "inc_high");
        wr(8'h00, 8'h10);
        repeat (4) @(posedge core_clk);
        chk("pol_idle", {per, poe, pin}, 34'h4);
        rd(8'h00, 34'h30, "out_status");
        wr(8'h00, 8'hc0);
        for (c = 0; c < 4; c++) begin
            wr(8'h04, 8'(c));
            cnt(2048, 1'b1, hi);
            cnt(2048, 1'b1, hi);
            chk("rises", hi, 34'(32 / dv[c]));
            chk("keep", 34'(keep), 34'(c == 2));
        end
        // enabled: a high byte alone must not reach the adder; the low byte write releases it
        wr(8'h04, 8'h01);
        wr(8'h18, 8'h40);
        cnt(2048, 1'b1, hi);
        chk("hold_only", hi, 34'h20);
        wr(8'h14, 8'h00);
        cnt(2048, 1'b1, hi);
        cnt(2048, 1'b1, hi);
        chk("inc_loaded", hi, 34'h10);
        wr(8'h18, 8'h80);
        wr(8'h14, 8'h00);
        rd(8'h1c, 34'h1, "flag");
        chk("irq_masked", 34'(irq), 34'h0);
        wr(8'h1c, 8'h0f);
        repeat (4) @(posedge core_clk);
        chk("irq", 34'(irq), 34'h1);
        for (p = 0; p < 10; p++) begin
            wr(8'h04, 8'(p % 5 * 32 + 1)); // widths stay below the 32-tick overflow interval
            wr(8'h00, 8'(193 + p / 5 * 16));
            cnt(70, 1'b0, hi);
            cnt(640, 1'b0, hi);
            chk("high", hi, 34'(p < 5 ? 20 << p : 640 - (20 << (p - 5))));
        end
        wr(8'h00, 8'h00);
        wr(8'h1c, 8'h0e);
        rd(8'h1c, 34'h0e, "flag_clr");
        wr(8'h00, 8'h10);
        rd(8'h1c, 34'h0f, "pol_irq");
        stop_test;
    end
endmodule : testbench
`default_nettype wire
